// ==== hdl/bitops_exec.sv ====
// Executes AND-with-file, bit clear, bit set and bit test-skip-when-zero.
// Assumes the file register read data for the current instruction's address
// arrives combinationally in the same cycle, from logic on mclk.
`timescale 1ns/10ps
`include "bitops_params.svh"
module bitops_exec import bitops_pkg::*; (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Instruction from fetch
  input wire logic [13:0] instr,
  // File register read port
  output logic [6:0] file_raddr,
  input wire logic [7:0] file_rdata,
  // File register write port
  output file_wr_t file_wr,
  // Core state
  output logic [7:0] accum,
  output logic skip_active,
  output logic zero_flag
);
  state_t s_q;
  state_t s_d;
  op_t op;
  logic dest;
  logic [2:0] bpos;
  logic [7:0] bmask;
  logic [7:0] and_res;

  assign file_raddr = instr[6:0];
  assign dest = instr[`DEST_BIT_POS];
  assign bpos = instr[`BITPOS_LSB +: 3];
  assign bmask = 8'h01 << bpos;
  assign and_res = s_q.accum & file_rdata;

  always_comb begin
    if (instr[13:8] == `OPC6_AND_FILE) begin
      op = OP_AND;
    end else if (instr[13:10] == `OPC4_BIT_CLEAR) begin
      op = OP_CLR;
    end else if (instr[13:10] == `OPC4_BIT_SET) begin
      op = OP_SET;
    end else if (instr[13:10] == `OPC4_BIT_TEST) begin
      op = OP_TEST;
    end else begin
      op = OP_NONE;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.wr = '0;
    s_d.squash = 1'b0;
    // A squashed word runs as a no-op whatever it decodes to.
    if (!s_q.squash) begin
      unique case (op)
        OP_AND: begin
          if (dest) begin
            s_d.wr = '{we: 1'b1, addr: file_raddr, data: and_res};
          end else begin
            s_d.accum = and_res;
          end
        end
        OP_CLR: s_d.wr = '{we: 1'b1, addr: file_raddr, data: file_rdata & ~bmask};
        OP_SET: s_d.wr = '{we: 1'b1, addr: file_raddr, data: file_rdata | bmask};
        OP_TEST: s_d.squash = ~file_rdata[bpos];
        OP_NONE: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '{accum: `ACCUM_RESET, squash: 1'b0, wr: '0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign accum = s_q.accum;
  assign skip_active = s_q.squash;
  assign file_wr = s_q.wr;
  // The flag watches the accumulator only, so an AND result sent to a file leaves it alone.
  assign zero_flag = (s_q.accum == 8'h00);

  // A skip lasts one enabled edge; frozen edges neither start nor end it.
  a_skip_on_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_TEST && !file_rdata[bpos] |=> s_q.squash)
    else $error("skip not taken on clear bit");

  a_run_on_one: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && op == OP_TEST && file_rdata[bpos] |=> !s_q.squash)
    else $error("skip taken on set bit");

  a_squash_is_nop: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && s_q.squash |=> !s_q.wr.we && s_q.accum == $past(s_q.accum))
    else $error("discarded instruction had an effect");

  a_squash_one_cycle: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && s_q.squash |=> !s_q.squash)
    else $error("skip lasted more than one cycle");

  a_test_bit_select: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_TEST
    |=> s_q.squash == !$past(file_rdata[instr[9:7]]))
    else $error("tested bit not the one selected");

  a_skip_needs_test: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !(op == OP_TEST && !s_q.squash)
    |=> !s_q.squash)
    else $error("skip started without a test");

  a_test_no_write: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_TEST
    |=> !s_q.wr.we && s_q.accum == $past(s_q.accum))
    else $error("bit test changed state");

  // The AND result lands in exactly one place, chosen by the destination bit.
  a_and_to_accum: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_AND && !dest
    |=> s_q.accum == $past(and_res) && !s_q.wr.we)
    else $error("AND to accumulator wrong");

  a_and_to_file: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_AND && dest
    |=> s_q.wr.we && s_q.wr.data == $past(and_res) && s_q.accum == $past(s_q.accum))
    else $error("AND to file wrong");

  a_accum_and_bits: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_AND && !dest
    |=> (s_q.accum & ~$past(s_q.accum)) == 8'h00)
    else $error("AND set an accumulator bit");

  a_accum_only_and: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !(op == OP_AND && !dest && !s_q.squash)
    |=> s_q.accum == $past(s_q.accum))
    else $error("accumulator changed without AND");

  a_field_width: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_AND && dest
    |=> s_q.wr.addr == $past(instr[6:0]))
    else $error("AND write address wrong");

  // Bit writes change only the selected bit and use the current read data.
  a_clear_one_bit: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_CLR
    |=> s_q.wr.we && s_q.wr.data == ($past(file_rdata) & ~$past(bmask)))
    else $error("bit clear wrong");

  a_cleared_bit_low: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_CLR
    |=> (s_q.wr.data & $past(bmask)) == 8'h00)
    else $error("cleared bit still high");

  a_clear_keeps_rest: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_CLR
    |=> (s_q.wr.data | $past(bmask)) == ($past(file_rdata) | $past(bmask)))
    else $error("bit clear touched other bits");

  a_set_one_bit: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_SET
    |=> s_q.wr.we && s_q.wr.data == ($past(file_rdata) | $past(bmask)))
    else $error("bit set wrong");

  a_set_bit_high: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && op == OP_SET
    |=> (s_q.wr.data & $past(bmask)) == $past(bmask))
    else $error("set bit still low");

  a_write_address: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && !s_q.squash && (op == OP_CLR || op == OP_SET)
    |=> s_q.wr.addr == $past(instr[6:0]))
    else $error("write address wrong");

  a_write_needs_op: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && (s_q.squash || !(op == OP_CLR || op == OP_SET || (op == OP_AND && dest)))
    |=> !s_q.wr.we)
    else $error("file write without a writing instruction");

  // Decode and the clock enable.
  a_decode_and: assert property (@(posedge mclk) disable iff (!arst_n)
    instr[13:8] == 6'h05 |-> op == OP_AND)
    else $error("AND not decoded");

  a_decode_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    instr[13:10] == `OPC4_BIT_CLEAR |-> op == OP_CLR)
    else $error("bit clear not decoded");

  a_decode_set: assert property (@(posedge mclk) disable iff (!arst_n)
    instr[13:10] == `OPC4_BIT_SET |-> op == OP_SET)
    else $error("bit set not decoded");

  a_decode_test: assert property (@(posedge mclk) disable iff (!arst_n)
    instr[13:10] == `OPC4_BIT_TEST |-> op == OP_TEST)
    else $error("bit test not decoded");

  a_decode_none: assert property (@(posedge mclk) disable iff (!arst_n)
    instr[13:8] != `OPC6_AND_FILE && instr[13:10] != `OPC4_BIT_CLEAR
    && instr[13:10] != `OPC4_BIT_SET && instr[13:10] != `OPC4_BIT_TEST |-> op == OP_NONE)
    else $error("undecoded word not a no-op");

  a_undecoded_nop: assert property (@(posedge mclk) disable iff (!arst_n)
    clk_en && op == OP_NONE
    |=> !s_q.wr.we && !s_q.squash && s_q.accum == $past(s_q.accum))
    else $error("undecoded word had an effect");

  a_freeze_when_off: assert property (@(posedge mclk) disable iff (!arst_n)
    !clk_en
    |=> s_q == $past(s_q))
    else $error("state moved while clock enable low");

  // Main scenarios that the random bench should reach.
  c_skip_taken: cover property (@(posedge mclk) disable iff (!arst_n) clk_en && s_q.squash);
  c_and_file: cover property (@(posedge mclk) disable iff (!arst_n)
    clk_en && op == OP_AND && dest && !s_q.squash);
  c_set_bit: cover property (@(posedge mclk) disable iff (!arst_n)
    clk_en && op == OP_SET && !s_q.squash);
  c_clear_bit: cover property (@(posedge mclk) disable iff (!arst_n)
    clk_en && op == OP_CLR && !s_q.squash);
  c_skip_not_taken: cover property (@(posedge mclk) disable iff (!arst_n)
    clk_en && op == OP_TEST && !s_q.squash && file_rdata[bpos]);
endmodule

// ==== hdl/bitops_params.svh ====
// Constants for the AND-with-file and bit-operation execution block.
// Assumes a 14-bit instruction word and 8-bit data path.
// Overview of operation
// - AND-with-file takes a 7-bit file address and a one-bit destination field.
// - AND result goes to accumulator when destination is 0, file when 1.
// - Bit clear, set and test take a 7-bit file address and 3-bit position.
// - Bit clear zeroes the selected bit and keeps the other bits.
// - Bit test skips the next instruction only when the selected bit is zero.
// - A taken skip replaces the fetched instruction by a no-op: two cycles.
`ifndef BITOPS_PARAMS_SVH
`define BITOPS_PARAMS_SVH
`define OPC6_AND_FILE 6'h05
`define OPC4_BIT_CLEAR 4'h4
`define OPC4_BIT_SET 4'h5
`define OPC4_BIT_TEST 4'h6
`define DEST_BIT_POS 7
`define BITPOS_LSB 7
`define ACCUM_RESET 8'h00
`endif

// ==== hdl/bitops_pkg.sv ====
// Types for the bit-operation execution block.
// Assumes the constants header is included alongside.
package bitops_pkg;
  typedef enum logic [4:0] {
    OP_NONE = 5'h01,
    OP_AND = 5'h02,
    OP_CLR = 5'h04,
    OP_SET = 5'h08,
    OP_TEST = 5'h10
  } op_t;
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;
  typedef struct packed {
    logic [7:0] accum;
    logic squash;
    file_wr_t wr;
  } state_t;
endpackage

// ==== verif/prog_mem_model.sv ====
// Program memory stand-in that hands over prefetched instruction words.
// Assumes the bench offers the word to fetch next in every cycle.
`timescale 1ns/10ps
module prog_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Words
  input wire logic [13:0] next_word,
  output logic [13:0] instr
);
  // A word is fetched one cycle ahead; reset fetches an undecoded word, a no-op.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) instr <= 14'h0000;
    else if (clk_en) instr <= next_word;
  end
endmodule

// ==== verif/and_bit_ops_skip_exec_tb.sv ====
// Random bench that checks bitops_exec against a model every cycle.
// Assumes prog_mem_model feeds the words; the bench drives read data.
`timescale 1ns/10ps
`include "bitops_params.svh"
module and_bit_ops_skip_exec_tb;
  import bitops_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic clk_en = 1'b0;
  logic [13:0] next_word = 14'h0000;
  logic [7:0] file_rdata = 8'h00;
  logic [13:0] instr;
  logic [6:0] file_raddr;
  file_wr_t file_wr;
  logic [7:0] accum;
  logic skip_active;
  logic zero_flag;
  logic [7:0] m_acc = 8'h00;
  logic m_sk = 1'b0;
  file_wr_t m_wr = '0;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int k;
  always #2.5 mclk = ~mclk;
  prog_mem_model prog_mem_model_i (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
    .next_word(next_word), .instr(instr));
  bitops_exec bitops_exec_i (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .instr(instr),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr(file_wr), .accum(accum),
    .skip_active(skip_active), .zero_flag(zero_flag));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    k = $urandom(32'h96A6);
    repeat (20) @(posedge mclk);
    #1 arst_n = 1'b1;
    repeat (2000) begin
      @(posedge mclk);
      #1;
      check(16'(accum), 16'(m_acc));
      check(16'(zero_flag), 16'(m_acc == 8'h00));
      check(16'(skip_active), 16'(m_sk));
      check(file_wr.we ? 16'(file_wr) : 16'h0000, m_wr.we ? 16'(m_wr) : 16'h0000);
      check(16'(file_raddr), 16'(instr[6:0]));
      clk_en = ($urandom % 8) != 0;
      file_rdata = 8'($urandom);
      k = $urandom % 5;
      next_word = 14'($urandom);
      if (k == 0) next_word[13:8] = `OPC6_AND_FILE;
      else if (k < 4) next_word[13:10] = 4'(k + 3);
      // The model reads the word now executing, so stimulus above cannot disturb it.
      if (clk_en) begin
        m_wr.we = 1'b0;
        if (m_sk) m_sk = 1'b0;
        else if (instr[13:8] == `OPC6_AND_FILE && instr[`DEST_BIT_POS])
          m_wr = {1'b1, instr[6:0], m_acc & file_rdata};
        else if (instr[13:8] == `OPC6_AND_FILE) m_acc = m_acc & file_rdata;
        else if (instr[13:10] == `OPC4_BIT_CLEAR)
          m_wr = {1'b1, instr[6:0], file_rdata & ~(8'h01 << instr[9:7])};
        else if (instr[13:10] == `OPC4_BIT_SET)
          m_wr = {1'b1, instr[6:0], file_rdata | (8'h01 << instr[9:7])};
        else if (instr[13:10] == `OPC4_BIT_TEST) m_sk = !file_rdata[instr[9:7]];
      end
    end
    test_done();
  end
endmodule
